// [design/pfa_top.sv]
// Purpose: flash sequencer with page guards and key checks
// Assumes: SFR writes and reads are single-cycle strobes
// Notes: erase walks the page, or the whole array for erase-all, byte by byte writing 0xFF
`timescale 1ns/1ps
`default_nettype none
module pfa_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    output logic o_stall
);
    pfa_pkg::pfa_state_type state_q, state_d;
    logic [7:0] cmd_q, cmd_d, ukey_q, ukey_d, pkey_q, pkey_d;
    logic [7:0] data_q, data_d, alo_q, alo_d, ahi_q, ahi_d;
    logic [7:0] wg_q [4], wg_d [4];
    logic [7:0] rg_q, rg_d, skey_q, skey_d, rdata_q, rdata_d;
    logic [13:0] fa_q, fa_d;
    logic [8:0] cnt_q, cnt_d;
    logic [2:0] ld_q, ld_d;
    logic stall_q, stall_d, erase_all_q, erase_all_d;
    logic arr_rd, arr_wr;
    logic [13:0] arr_addr;
    logic [7:0] arr_wdata, arr_rdata;
    logic [13:0] cur_addr;
    logic [4:0] cur_page;
    logic start, key_ok;

    // ******************************
    // Guard lookups
    // ******************************
    function automatic logic page_locked(input logic [4:0] pg,
            input logic [7:0] g0, g1, g2, g3);
        logic [31:0] bits;
        bits = {g3, g2, g1, g0};
        page_locked = ~bits[pg];
    endfunction

    function automatic logic page_rlocked(input logic [4:0] pg,
            input logic [7:0] rg);
        page_rlocked = ~rg[pg[4:2]];
    endfunction

    assign cur_addr = {ahi_q[5:0], alo_q};
    assign cur_page = cur_addr[13:9];
    assign start = i_sfr_wr && i_sfr_addr == pfa_pkg::REG_CMD
        && !stall_q;
    assign key_ok = ukey_q == pfa_pkg::UNLOCK_VAL;

    pfa_array u_array (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .i_addr(arr_addr),
        .i_rd(arr_rd),
        .i_wr(arr_wr),
        .i_wdata(arr_wdata),
        .o_rdata(arr_rdata)
    );

    // ******************************
    // Sequencer
    // ******************************
    always_comb begin
        logic locked;
        locked = page_locked(cur_page, wg_q[0], wg_q[1], wg_q[2],
            wg_q[3]);
        state_d = state_q;
        cmd_d = cmd_q;
        ukey_d = ukey_q;
        pkey_d = pkey_q;
        data_d = data_q;
        alo_d = alo_q;
        ahi_d = ahi_q;
        wg_d = wg_q;
        rg_d = rg_q;
        skey_d = skey_q;
        fa_d = fa_q;
        cnt_d = cnt_q;
        ld_d = ld_q;
        stall_d = stall_q;
        erase_all_d = erase_all_q;
        arr_rd = 1'b0;
        arr_wr = 1'b0;
        arr_addr = fa_q;
        arr_wdata = pfa_pkg::ERASED;
        if (i_sfr_wr && !stall_q) begin
            case (i_sfr_addr)
                pfa_pkg::REG_CMD: cmd_d = i_sfr_wdata;
                pfa_pkg::REG_UKEY: ukey_d = i_sfr_wdata;
                pfa_pkg::REG_PKEY: pkey_d = i_sfr_wdata;
                pfa_pkg::REG_DATA: data_d = i_sfr_wdata;
                pfa_pkg::REG_WEG_LO: wg_d[0] = i_sfr_wdata;
                pfa_pkg::REG_WEG_HI: wg_d[1] = i_sfr_wdata;
                pfa_pkg::REG_RG: rg_d = i_sfr_wdata;
                pfa_pkg::REG_ADR_LO: alo_d = i_sfr_wdata;
                pfa_pkg::REG_ADR_HI: ahi_d = i_sfr_wdata;
                default: ;
            endcase
        end
        case (state_q)
            pfa_pkg::ST_IDLE: begin
                // Load stored guards from the top page after reset
                if (ld_q != 3'h6) begin
                    arr_rd = 1'b1;
                    case (ld_q)
                        3'h0: arr_addr = pfa_pkg::ADR_GUARD0;
                        3'h1: arr_addr = pfa_pkg::ADR_GUARD1;
                        3'h2: arr_addr = pfa_pkg::ADR_GUARD2;
                        3'h3: arr_addr = pfa_pkg::ADR_GUARD3;
                        3'h4: arr_addr = pfa_pkg::ADR_RGUARD;
                        default: arr_addr = pfa_pkg::ADR_PKEY;
                    endcase
                    ld_d = ld_q + 3'h1;
                    stall_d = 1'b1;
                    state_d = pfa_pkg::ST_RDWAIT;
                end else if (start) begin
                    stall_d = 1'b1;
                    ukey_d = pfa_pkg::RST_KEY;
                    fa_d = {cur_page, 9'h000};
                    cnt_d = 9'h000;
                    erase_all_d = 1'b0;
                    state_d = pfa_pkg::ST_DONE;
                    if (key_ok) begin
                        case (i_sfr_wdata)
                            pfa_pkg::CMD_WRITE: begin
                                fa_d = cur_addr;
                                if (!locked)
                                    state_d = pfa_pkg::ST_WRITE;
                            end
                            pfa_pkg::CMD_ERASE_PG,
                            pfa_pkg::CMD_ERASE_WR: begin
                                if (!locked)
                                    state_d = pfa_pkg::ST_ERASE;
                            end
                            pfa_pkg::CMD_ERASE_ALL: begin
                                fa_d = 14'h0000;
                                erase_all_d = 1'b1;
                                state_d = pfa_pkg::ST_ERASE;
                            end
                            pfa_pkg::CMD_READ: begin
                                fa_d = cur_addr;
                                state_d = pfa_pkg::ST_READ;
                            end
                            pfa_pkg::CMD_PROTECT: begin
                                if (skey_q == pfa_pkg::ERASED
                                    || skey_q == pkey_q) begin
                                    cnt_d = 9'h000;
                                    state_d = pfa_pkg::ST_PROT;
                                end
                            end
                            default: ;
                        endcase
                    end
                end
            end
            pfa_pkg::ST_ERASE: begin
                arr_wr = 1'b1;
                arr_wdata = pfa_pkg::ERASED;
                fa_d = fa_q + 14'h0001;
                // Erase stores 0xFF into every byte of the span
                if (fa_q[8:0] == 9'h1FF && (!erase_all_q
                    || fa_q == 14'h3FFF)) begin
                    fa_d = cur_addr;
                    state_d = (cmd_q == pfa_pkg::CMD_ERASE_WR)
                        ? pfa_pkg::ST_WRITE : pfa_pkg::ST_DONE;
                    if (erase_all_q || cur_page == pfa_pkg::TOP_PAGE) begin
                        wg_d = '{default: pfa_pkg::RST_GUARD};
                        rg_d = pfa_pkg::RST_GUARD;
                        skey_d = pfa_pkg::ERASED;
                    end
                end
            end
            pfa_pkg::ST_WRITE: begin
                arr_wr = 1'b1;
                arr_wdata = data_q;
                state_d = pfa_pkg::ST_DONE;
            end
            pfa_pkg::ST_READ: begin
                if (page_rlocked(fa_q[13:9], rg_q)) begin
                    data_d = pfa_pkg::ERASED;
                    state_d = pfa_pkg::ST_DONE;
                end else begin
                    arr_rd = 1'b1;
                    ld_d = 3'h7;
                    state_d = pfa_pkg::ST_RDWAIT;
                end
            end
            pfa_pkg::ST_RDWAIT: begin
                state_d = pfa_pkg::ST_IDLE;
                // Hold stall through the whole boot load
                stall_d = (ld_q < 3'h6);
                case (ld_q)
                    3'h1: wg_d[0] = arr_rdata;
                    3'h2: wg_d[1] = arr_rdata;
                    3'h3: wg_d[2] = arr_rdata;
                    3'h4: wg_d[3] = arr_rdata;
                    3'h5: rg_d = arr_rdata;
                    3'h6: skey_d = arr_rdata;
                    default: begin
                        data_d = arr_rdata;
                        ld_d = 3'h6;
                    end
                endcase
            end
            pfa_pkg::ST_PROT: begin
                // Store guards; top page always write protected
                arr_wr = 1'b1;
                cnt_d = cnt_q + 9'h001;
                case (cnt_q[2:0])
                    3'h0: begin
                        arr_addr = pfa_pkg::ADR_GUARD0;
                        arr_wdata = wg_q[0];
                    end
                    3'h1: begin
                        arr_addr = pfa_pkg::ADR_GUARD1;
                        arr_wdata = wg_q[1];
                    end
                    3'h2: begin
                        arr_addr = pfa_pkg::ADR_GUARD2;
                        arr_wdata = wg_q[2];
                    end
                    3'h3: begin
                        arr_addr = pfa_pkg::ADR_GUARD3;
                        arr_wdata = {1'b0, wg_q[3][6:0]};
                    end
                    3'h4: begin
                        arr_addr = pfa_pkg::ADR_RGUARD;
                        arr_wdata = rg_q;
                    end
                    default: begin
                        arr_addr = pfa_pkg::ADR_PKEY;
                        arr_wdata = pkey_q;
                        wg_d[0] = wg_q[0] & wg_q[0];
                        wg_d[3] = {1'b0, wg_q[3][6:0]};
                        skey_d = skey_q & pkey_q;
                        state_d = pfa_pkg::ST_DONE;
                    end
                endcase
            end
            pfa_pkg::ST_DONE: begin
                stall_d = 1'b0;
                state_d = pfa_pkg::ST_IDLE;
            end
            default: state_d = pfa_pkg::ST_IDLE;
        endcase
        // Read mux
        case (i_sfr_addr)
            pfa_pkg::REG_CMD: rdata_d = cmd_d;
            pfa_pkg::REG_UKEY: rdata_d = ukey_d;
            pfa_pkg::REG_PKEY: rdata_d = pkey_d;
            pfa_pkg::REG_DATA: rdata_d = data_d;
            pfa_pkg::REG_WEG_LO: rdata_d = wg_d[0];
            pfa_pkg::REG_WEG_HI: rdata_d = wg_d[1];
            pfa_pkg::REG_RG: rdata_d = rg_d;
            pfa_pkg::REG_ADR_LO: rdata_d = alo_d;
            pfa_pkg::REG_ADR_HI: rdata_d = ahi_d;
            default: rdata_d = 8'h00;
        endcase
    end

    // ******************************
    // Registers
    // ******************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= pfa_pkg::ST_IDLE;
            cmd_q <= pfa_pkg::RST_CMD;
            ukey_q <= pfa_pkg::RST_KEY;
            pkey_q <= pfa_pkg::RST_KEY;
            data_q <= pfa_pkg::RST_DATA;
            alo_q <= pfa_pkg::RST_ADR;
            ahi_q <= pfa_pkg::RST_ADR;
            wg_q <= '{default: pfa_pkg::RST_GUARD};
            rg_q <= pfa_pkg::RST_GUARD;
            skey_q <= pfa_pkg::ERASED;
            rdata_q <= 8'h00;
            fa_q <= 14'h0000;
            cnt_q <= 9'h000;
            ld_q <= 3'h0;
            stall_q <= 1'b1;
            erase_all_q <= 1'b0;
        end else if (i_ce) begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            ukey_q <= ukey_d;
            pkey_q <= pkey_d;
            data_q <= data_d;
            alo_q <= alo_d;
            ahi_q <= ahi_d;
            wg_q <= wg_d;
            rg_q <= rg_d;
            skey_q <= skey_d;
            rdata_q <= rdata_d;
            fa_q <= fa_d;
            cnt_q <= cnt_d;
            ld_q <= ld_d;
            stall_q <= stall_d;
            erase_all_q <= erase_all_d;
        end
    end

    assign o_sfr_rdata = rdata_q;
    assign o_stall = stall_q;
endmodule
`default_nettype wire

// [design/pfa_pkg.sv]
// Purpose: constants for the paged flash access and protection block
// Assumes: byte-wide SFR port of the host processor, 100 MHz clock
// Notes: flash array is modelled by pfa_array behind the sequencer
package pfa_pkg;
    localparam int ADDR_W = 14;
    localparam int PAGE_W = 5;
    localparam int OFS_W = 9;
    localparam logic [PAGE_W-1:0] TOP_PAGE = 5'h1F;
    // Protection bytes at the end of page 31
    localparam logic [ADDR_W-1:0] ADR_GUARD0 = 14'h3FFB;
    localparam logic [ADDR_W-1:0] ADR_GUARD1 = 14'h3FFC;
    localparam logic [ADDR_W-1:0] ADR_GUARD2 = 14'h3FFD;
    localparam logic [ADDR_W-1:0] ADR_GUARD3 = 14'h3FFE;
    localparam logic [ADDR_W-1:0] ADR_RGUARD = 14'h3FFF;
    localparam logic [ADDR_W-1:0] ADR_PKEY = 14'h3FFA;
    localparam logic [OFS_W-1:0] USER_LIMIT = 9'h1FA;
    // Register addresses
    localparam logic [7:0] REG_CMD = 8'hB9;
    localparam logic [7:0] REG_UKEY = 8'hBA;
    localparam logic [7:0] REG_PKEY = 8'hBB;
    localparam logic [7:0] REG_DATA = 8'hBC;
    localparam logic [7:0] REG_WEG_LO = 8'hBD;
    localparam logic [7:0] REG_WEG_HI = 8'hBE;
    localparam logic [7:0] REG_RG = 8'hBF;
    localparam logic [7:0] REG_ADR_LO = 8'hC6;
    localparam logic [7:0] REG_ADR_HI = 8'hC7;
    // Reset values
    localparam logic [7:0] RST_CMD = 8'h00;
    localparam logic [7:0] RST_KEY = 8'hFF;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_GUARD = 8'hFF;
    localparam logic [7:0] RST_ADR = 8'h00;
    localparam logic [7:0] UNLOCK_VAL = 8'h3B;
    localparam logic [7:0] ERASED = 8'hFF;
    // Commands
    localparam logic [7:0] CMD_WRITE = 8'h01;
    localparam logic [7:0] CMD_ERASE_PG = 8'h02;
    localparam logic [7:0] CMD_ERASE_ALL = 8'h03;
    localparam logic [7:0] CMD_READ = 8'h04;
    localparam logic [7:0] CMD_ERASE_WR = 8'h05;
    localparam logic [7:0] CMD_PROTECT = 8'h08;
    // Sequencer
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ERASE = 7'h02,
        ST_WRITE = 7'h04,
        ST_READ = 7'h08,
        ST_RDWAIT = 7'h10,
        ST_PROT = 7'h20,
        ST_DONE = 7'h40
    } pfa_state_type;
endpackage

// [design/pfa_array.sv]
// Purpose: 16 kB flash array model, byte port, no erase of its own
// Assumes: sequencer erases by storing 0xFF byte by byte
// Notes: read data comes from a register, one cycle latency
`timescale 1ns/1ps
`default_nettype none
module pfa_array (
    input wire logic i_clk,
    input wire logic i_ce,
    input wire logic [13:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:16383];
    logic [7:0] rdata_q;

    assign o_rdata = rdata_q;

    // Plain byte store; program expects an erased byte
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            if (i_wr) begin
                mem[i_addr] <= i_wdata;
            end
            if (i_rd) begin
                rdata_q <= mem[i_addr];
            end
        end
    end
endmodule
`default_nettype wire

// [dv/pfa_top_sva.sv]
// Purpose: port checker for the flash sequencer
// Assumes: one clock, sync reset
// Notes: key_q mirrors the unlock register seen at the port
`timescale 1ns/1ps
`default_nettype none
module pfa_top_sva (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic o_stall
);
    logic [7:0] key_q, key_d;
    logic [15:0] cnt_q, cnt_d;
    logic take, cmd, unl;
    assign take = i_ce && i_sfr_wr && !o_stall;
    assign cmd = take && i_sfr_addr == pfa_pkg::REG_CMD;
    assign unl = key_q == pfa_pkg::UNLOCK_VAL;
    always_comb begin
        key_d = key_q;
        if (cmd) begin
            key_d = pfa_pkg::RST_KEY;
        end else if (take && i_sfr_addr == pfa_pkg::REG_UKEY) begin
            key_d = i_sfr_wdata;
        end
        cnt_d = o_stall ? cnt_q + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            key_q <= pfa_pkg::RST_KEY;
            cnt_q <= 16'h0000;
        end else begin
            key_q <= key_d;
            cnt_q <= cnt_d;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_stall_in_reset: assert property (disable iff (1'b0)
        i_rst |=> o_stall) else $error("stall low after reset");
    a_rdata_reset: assert property (disable iff (1'b0)
        i_rst |=> o_sfr_rdata == 8'h00) else $error("read data not clear");
    a_cmd_stalls: assert property (cmd |=> o_stall)
        else $error("command did not stall");
    a_locked_short: assert property (cmd && !unl
        |=> o_stall ##[1:3] !o_stall) else $error("locked command ran");
    a_short_ops: assert property (cmd && unl && (i_sfr_wdata ==
        pfa_pkg::CMD_WRITE || i_sfr_wdata == pfa_pkg::CMD_READ)
        |=> o_stall ##[1:4] !o_stall) else $error("byte op length");
    a_protect_len: assert property (cmd && unl &&
        i_sfr_wdata == pfa_pkg::CMD_PROTECT |=> o_stall ##[1:9] !o_stall)
        else $error("protect op length");
    a_key_restore: assert property (i_ce && !i_sfr_wr && !o_stall &&
        i_sfr_addr == pfa_pkg::REG_UKEY |=> o_sfr_rdata == $past(key_q))
        else $error("unlock key value wrong");
    a_wr_readback: assert property (take && (i_sfr_addr == 8'hBC ||
        i_sfr_addr == 8'hC6 || i_sfr_addr == 8'hBB)
        |=> o_sfr_rdata == $past(i_sfr_wdata)) else $error("readback");
    a_stall_bound: assert property (cnt_q <= 16'h4074)
        else $error("stall too long");
endmodule
bind pfa_top pfa_top_sva pfa_top_sva_i (.i_clk(i_clk), .i_rst(i_rst),
    .i_ce(i_ce), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
    .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .o_stall(o_stall));
`default_nettype wire

// [dv/pfa_cpu.sv]
// Purpose: processor side of the SFR port
// Assumes: requests only while stall is low
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module pfa_cpu (
    input wire logic i_clk,
    input wire logic i_stall,
    input wire logic [7:0] i_rdata,
    output logic o_ce,
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic [7:0] o_wdata
);
    initial begin
        o_ce = 1'b1;
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_wdata = 8'h00;
    end
    // Program counter held while stalled
    task automatic idle();
        int n;
        n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (i_stall !== 1'b0 && n < 20000);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        idle();
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        idle();
        o_addr = a;
        @(posedge i_clk);
        #1;
        d = i_rdata;
        o_addr = ~a;
    endtask
    task automatic hold(input logic en);
        o_ce = en;
    endtask
    task automatic cmd(input logic [7:0] k, input logic [7:0] c);
        wr(pfa_pkg::REG_UKEY, k);
        wr(pfa_pkg::REG_CMD, c);
        idle();
    endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Purpose: self-checking bench for the flash sequencer
// Assumes: array is erased before any user data is checked
// Notes: mem, wg and rg form the reference model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_clk, i_rst, ce, wr, stall;
    logic [7:0] addr, wdata, rdata, v;
    logic [7:0] mem [16384];
    logic [31:0] wg;
    logic [7:0] rg;
    logic [13:0] qa [$];
    int bad_count, n_compared, i;
    localparam logic [7:0] RA [9] = '{8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD,
        8'hBE, 8'hBF, 8'hC6, 8'hC7};
    localparam logic [7:0] RV [9] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF,
        8'hFF, 8'hFF, 8'h00, 8'h00};
    pfa_top pfa_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
        .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata),
        .o_sfr_rdata(rdata), .o_stall(stall));
    pfa_cpu pfa_cpu_i (.i_clk(i_clk), .i_stall(stall), .i_rdata(rdata),
        .o_ce(ce), .o_addr(addr), .o_wr(wr), .o_wdata(wdata));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic summarize();
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rst();
        i_rst = 1'b1;
        repeat (16) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
    endtask
    // ****************************************
    // Flash operation with model update
    // ****************************************
    task automatic op(input logic [7:0] k, input logic [13:0] ad,
        input logic [7:0] c, input logic [7:0] dt);
        logic [4:0] pg;
        pg = ad[13:9];
        pfa_cpu_i.wr(8'hC7, {2'b00, ad[13:8]});
        pfa_cpu_i.wr(8'hC6, ad[7:0]);
        pfa_cpu_i.wr(8'hBC, dt);
        pfa_cpu_i.cmd(k, c);
        if (k != 8'h3B) c = 8'h00;
        if (wg[pg] && (c == 8'h02 || c == 8'h05)) begin
            for (int j = 0; j < 512; j++) mem[{pg, j[8:0]}] = 8'hFF;
        end
        if (wg[pg] && (c == 8'h01 || c == 8'h05)) mem[ad] = mem[ad] & dt;
        if (c == 8'h04) begin
            pfa_cpu_i.rd(8'hBC, v);
            chk(v, rg[ad[13:11]] ? mem[ad] : 8'hFF);
        end
    endtask
    initial begin
        i_rst = 1'b1;
        bad_count = 0;
        n_compared = 0;
        i = $urandom(46608);
        wg = 32'hFFFFFFFF;
        rg = 8'hFF;
        rst();
        op(8'h3B, 14'h0000, 8'h03, 8'h00);
        for (i = 0; i < 16384; i++) mem[i] = 8'hFF;
        rst();
        for (i = 0; i < 9; i++) begin
            pfa_cpu_i.rd(RA[i], v);
            chk(v, RV[i]);
        end
        // Write while clock enable is low must not land
        pfa_cpu_i.hold(1'b0);
        pfa_cpu_i.wr(8'hBC, 8'hA5);
        pfa_cpu_i.hold(1'b1);
        pfa_cpu_i.rd(8'hBC, v);
        chk(v, 8'h00);
        for (i = 0; i < 6; i++) begin
            qa.push_back({5'(i * 5), 9'($urandom)});
            op(8'h3B, qa[i], 8'h01, 8'($urandom));
            op(8'h3B, qa[i], 8'h04, 8'h00);
        end
        op(8'h3B, qa[0], 8'h02, 8'h00);
        op(8'h3B, qa[0], 8'h04, 8'h00);
        op(8'h3B, qa[1], 8'h05, 8'($urandom));
        op(8'h3B, qa[1], 8'h04, 8'h00);
        op(8'h3B, qa[1] ^ 14'h0001, 8'h04, 8'h00);
        op(8'h3A, qa[2], 8'h01, 8'h00);
        pfa_cpu_i.rd(8'hBA, v);
        chk(v, 8'hFF);
        op(8'h3B, qa[2], 8'h04, 8'h00);
        pfa_cpu_i.wr(8'hBD, 8'hFD);
        pfa_cpu_i.wr(8'hBF, 8'hF7);
        pfa_cpu_i.wr(8'hBB, 8'h5A);
        op(8'h3B, 14'h0000, 8'h08, 8'h00);
        mem[14'h3FFA] = 8'h5A;
        mem[14'h3FFB] = 8'hFD;
        mem[14'h3FFE] = 8'h7F;
        mem[14'h3FFF] = 8'hF7;
        wg = 32'h7FFFFFFD;
        rg = 8'hF7;
        rst();
        pfa_cpu_i.rd(8'hBD, v);
        chk(v, 8'hFD);
        pfa_cpu_i.rd(8'hBF, v);
        chk(v, 8'hF7);
        op(8'h3B, qa[3], 8'h04, 8'h00);
        op(8'h3B, qa[2], 8'h04, 8'h00);
        op(8'h3B, 14'h0234, 8'h01, 8'h00);
        op(8'h3B, 14'h0234, 8'h04, 8'h00);
        op(8'h3B, 14'h3E10, 8'h01, 8'h00);
        op(8'h3B, 14'h3E10, 8'h04, 8'h00);
        for (i = 0; i < 6; i++) op(8'h3B, 14'(16378 + i), 8'h04, 8'h00);
        pfa_cpu_i.wr(8'hBB, 8'h11);
        pfa_cpu_i.wr(8'hBD, 8'h00);
        op(8'h3B, 14'h0000, 8'h08, 8'h00);
        rst();
        op(8'h3B, 14'h3FFB, 8'h04, 8'h00);
        summarize();
    end
    initial begin
        repeat (40000) @(posedge i_clk);
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
